// ===== hw/crs_pkg.sv
// Purpose: shared constants and types for the cpu bus register set
// Assumes: 40 MHz clk, active-low load controls on the test pins
// Notes: bus offsets are byte addresses of 32-bit words
package crs_pkg;

	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 4;
	localparam int AVS_AW = 5;
	localparam int AVS_DW = 32;

	// test pin positions and instruction nibble bounds
	localparam int PIN_LOAD_A = 4;
	localparam int PIN_LOAD_B = 5;
	localparam int PIN_SEL_LO = 6;
	localparam int PIN_SEL_HI = 7;
	localparam int NIB_HI = 7;
	localparam int NIB_LO_TOP = 3;

	// register map
	localparam logic [AVS_AW-1:0] OFS_CTRL = 5'h00;
	localparam logic [AVS_AW-1:0] OFS_INSTR = 5'h04;
	localparam logic [AVS_AW-1:0] OFS_OUTREG = 5'h08;
	localparam logic [AVS_AW-1:0] OFS_OPERAND = 5'h0C;
	localparam logic [AVS_AW-1:0] OFS_MEMDATA = 5'h10;
	localparam logic [AVS_AW-1:0] OFS_MEMADDR = 5'h14;
	localparam logic [AVS_AW-1:0] OFS_STATUS = 5'h18;

	// control register fields
	localparam int CTRL_OVR_BIT = 0;
	localparam int CTRL_SEL_LO = 1;
	localparam int CTRL_SEL_HI = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
	localparam logic [AVS_DW-1:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		CRS_SEL_INSTR,
		CRS_SEL_OUTPUT,
		CRS_SEL_OPERAND,
		CRS_SEL_MEMIN
	} crs_sel_e;

	typedef struct packed {
		logic [DATA_W-1:0] instr;
		logic [DATA_W-1:0] outReg;
		logic [DATA_W-1:0] operand;
		logic [DATA_W-1:0] memData;
		logic [ADDR_W-1:0] memAddr;
	} crs_regs_s;

	typedef struct packed {
		logic [DATA_W-1:0] pinOut;
		logic [DATA_W-1:0] pinOe;
	} crs_pins_s;

endpackage

// ===== hw/crs_register_set.sv
// Purpose: instruction, output, operand and memory-input/address registers
// Assumes: pins synchronous to clk; load controls active low
// Notes: one register, or the memory data/address pair, owns the test pins at a time; readable over Avalon-MM
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// RULE1 - all registers change on rising clock edge
// RULE2 - instruction register holds opcode and operand nibbles
// RULE3 - clear zeroes the instruction register
// RULE4 - separate enable drives instruction onto bus
// RULE5 - instruction selection uses its documented test pins
// RULE6 - output register loads only when commanded
// RULE7 - output register always feeds the display
// RULE8 - output selection uses its documented test pins
// RULE9 - operand register loads when commanded, else holds
// RULE10 - operand register always feeds the adder
// RULE11 - operand selection uses its documented test pins
// RULE12 - two loads pick data, address or neither; here both low loads both
// RULE13 - address register keeps four bus bits
// RULE14 - data register always feeds memory write data
// RULE15 - memory pair selection uses its test pins
// RULE16 - controls are active low, one edge minimum
// RULE17 - two select pins pick the register
// RULE18 - only mapped bidirectional pins become outputs
module crs_register_set (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [crs_pkg::DATA_W-1:0] uiIn,
	input wire logic [crs_pkg::DATA_W-1:0] uioIn,
	input wire logic instr_clear_n,
	output logic [crs_pkg::DATA_W-1:0] uoOut,
	output logic [crs_pkg::DATA_W-1:0] uioOut,
	output logic [crs_pkg::DATA_W-1:0] uioOe,
	output logic [crs_pkg::DATA_W-1:0] wBusOut,
	output logic wBusOe,
	output logic [crs_pkg::NIB_W-1:0] instrOpcode,
	output logic [crs_pkg::NIB_W-1:0] instrOperand,
	output logic [crs_pkg::DATA_W-1:0] displayValue,
	output logic [crs_pkg::DATA_W-1:0] adderOperand,
	output logic [crs_pkg::DATA_W-1:0] memWriteData,
	output logic [crs_pkg::ADDR_W-1:0] memAddress,
	input wire logic [crs_pkg::AVS_AW-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [crs_pkg::AVS_DW-1:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [crs_pkg::AVS_DW-1:0] avsReadData,
	output logic avsWaitRequest
);
	import crs_pkg::*;

	crs_regs_s regs;
	crs_pins_s pins;
	logic [2:0] ctrl;
	logic avsAck;

	// selection: software override wins over the select pins
	wire [1:0] pinSel = uioIn[PIN_SEL_HI:PIN_SEL_LO]; // RULE17
	wire [1:0] ctrlSel = ctrl[CTRL_SEL_HI:CTRL_SEL_LO];
	wire ovrEn = ctrl[CTRL_OVR_BIT];
	crs_sel_e sel;
	assign sel = crs_sel_e'(ovrEn ? ctrlSel : pinSel); // RULE17

	wire selInstr = (sel == CRS_SEL_INSTR);
	wire selOutput = (sel == CRS_SEL_OUTPUT);
	wire selOperand = (sel == CRS_SEL_OPERAND);
	wire selMemIn = (sel == CRS_SEL_MEMIN);

	// load controls are active low; a low level at an edge loads
	wire instr_load_n = uioIn[PIN_LOAD_A]; // RULE5 RULE16
	wire instr_bus_drive_n = uioIn[PIN_LOAD_B]; // RULE5
	wire output_reg_wr_n = uioIn[PIN_LOAD_A]; // RULE8
	wire operand_reg_wr_n = uioIn[PIN_LOAD_A]; // RULE11
	wire mem_data_reg_wr_n = uioIn[PIN_LOAD_A]; // RULE15
	wire addr_reg_wr_n = uioIn[PIN_LOAD_B]; // RULE15

	wire loadInstr = selInstr & ~instr_load_n;
	wire loadOutput = selOutput & ~output_reg_wr_n; // RULE6
	wire loadOperand = selOperand & ~operand_reg_wr_n; // RULE9
	wire loadMemData = selMemIn & ~mem_data_reg_wr_n; // RULE12
	wire loadMemAddr = selMemIn & ~addr_reg_wr_n; // RULE12

	// next values of the register set
	crs_regs_s next_regs;
	always_comb begin
		next_regs = regs;
		if (!instr_clear_n) begin
			next_regs.instr = BYTE_ZERO; // RULE3
		end else if (loadInstr) begin
			next_regs.instr = uiIn; // RULE2
		end
		if (loadOutput) begin
			next_regs.outReg = uiIn; // RULE6
		end
		if (loadOperand) begin
			next_regs.operand = uiIn; // RULE9
		end
		if (loadMemData) begin
			next_regs.memData = uiIn; // RULE12
		end
		if (loadMemAddr) begin
			next_regs.memAddr = uiIn[ADDR_W-1:0]; // RULE13
		end
	end

	// clear is sampled at the edge, so nothing changes between edges
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regs <= '0;
		end else begin
			regs <= next_regs; // RULE1
		end
	end

	// test pin image of the selected register
	crs_pins_s next_pins;
	always_comb begin
		next_pins.pinOut = BYTE_ZERO;
		next_pins.pinOe = BYTE_ZERO;
		unique case (sel)
			CRS_SEL_INSTR: begin
				next_pins.pinOut[NIB_W-1:0] = next_regs.instr[NIB_HI:NIB_W]; // RULE5
				next_pins.pinOe[NIB_W-1:0] = {NIB_W{1'b1}}; // RULE18
			end
			CRS_SEL_MEMIN: begin
				next_pins.pinOut[ADDR_W-1:0] = next_regs.memAddr; // RULE15
				next_pins.pinOe[ADDR_W-1:0] = {ADDR_W{1'b1}}; // RULE18
			end
			CRS_SEL_OUTPUT, CRS_SEL_OPERAND: begin
				next_pins.pinOut = BYTE_ZERO;
			end
		endcase
	end

	logic [DATA_W-1:0] next_uo;
	always_comb begin
		unique case (sel)
			CRS_SEL_INSTR: next_uo = {NIB_ZERO, next_regs.instr[NIB_LO_TOP:0]}; // RULE5
			CRS_SEL_OUTPUT: next_uo = next_regs.outReg; // RULE8
			CRS_SEL_OPERAND: next_uo = next_regs.operand; // RULE11
			CRS_SEL_MEMIN: next_uo = next_regs.memData; // RULE15
		endcase
	end

	// pins follow the register flops in the same edge, no extra lag
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pins <= '0;
			uoOut <= BYTE_ZERO;
		end else begin
			pins <= next_pins;
			uoOut <= next_uo;
		end
	end
	assign uioOut = pins.pinOut;
	assign uioOe = pins.pinOe; // RULE18

	// instruction back onto the shared bus, released when disabled
	assign wBusOut = regs.instr;
	assign wBusOe = selInstr & ~instr_bus_drive_n; // RULE4

	assign instrOpcode = regs.instr[NIB_HI:NIB_W]; // RULE2
	assign instrOperand = regs.instr[NIB_LO_TOP:0]; // RULE2
	assign displayValue = regs.outReg; // RULE7
	assign adderOperand = regs.operand; // RULE10
	assign memWriteData = regs.memData; // RULE14
	assign memAddress = regs.memAddr; // RULE13

	// avalon slave: one wait state, read data registered
	wire avsReq = avsRead | avsWrite;
	assign avsWaitRequest = avsReq & ~avsAck;
	wire avsTake = avsReq & ~avsAck;
	// write lands at the edge where waitrequest is seen low, as the master expects
	wire wrCtrl = avsWrite & avsAck & (avsAddress == OFS_CTRL) & avsByteEnable[0];

	logic [AVS_DW-1:0] rdMux;
	always_comb begin
		rdMux = WORD_ZERO;
		unique case (avsAddress)
			OFS_CTRL: rdMux[2:0] = ctrl;
			OFS_INSTR: rdMux[DATA_W-1:0] = regs.instr;
			OFS_OUTREG: rdMux[DATA_W-1:0] = regs.outReg;
			OFS_OPERAND: rdMux[DATA_W-1:0] = regs.operand;
			OFS_MEMDATA: rdMux[DATA_W-1:0] = regs.memData;
			OFS_MEMADDR: rdMux[ADDR_W-1:0] = regs.memAddr;
			OFS_STATUS: rdMux[2:0] = {wBusOe, sel};
			default: rdMux = WORD_ZERO;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avsAck <= 1'b0;
			avsReadData <= WORD_ZERO;
			ctrl <= CTRL_RESET;
		end else begin
			avsAck <= avsTake;
			if (avsRead && avsTake) begin
				avsReadData <= rdMux;
			end
			if (wrCtrl) begin
				ctrl <= avsWriteData[2:0];
			end
		end
	end

endmodule

// ===== tb/crs_register_set_asserts.sv
// Purpose: timing checks on the register set pins
// Assumes: control override left off
// Notes: each load shows one edge later
`timescale 1ns/1ps
module crs_register_set_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] uiIn,
	input wire logic [7:0] uioIn,
	input wire logic instr_clear_n,
	input wire logic wBusOe,
	input wire logic [7:0] wBusOut,
	input wire logic [3:0] instrOpcode,
	input wire logic [3:0] instrOperand,
	input wire logic [7:0] displayValue,
	input wire logic [7:0] adderOperand,
	input wire logic [7:0] memWriteData,
	input wire logic [3:0] memAddress
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic [1:0] s = uioIn[7:6];
	wire logic ldA = !uioIn[4];
	wire logic ldB = !uioIn[5];
	property p_out_ld; s == 2'h1 && ldA |=> displayValue == $past(uiIn); endproperty
	a_out_ld: assert property (p_out_ld) else $error("output load");
	property p_out_hold; !(s == 2'h1 && ldA) |=> $stable(displayValue); endproperty
	a_out_hold: assert property (p_out_hold) else $error("output hold");
	property p_opnd_ld; s == 2'h2 && ldA |=> adderOperand == $past(uiIn); endproperty
	a_opnd_ld: assert property (p_opnd_ld) else $error("operand load");
	property p_ir_clr; !instr_clear_n |=> {instrOpcode, instrOperand} == 8'h00; endproperty
	a_ir_clr: assert property (p_ir_clr) else $error("instr clear");
	property p_ir_ld;
		s == 2'h0 && ldA && instr_clear_n |=> {instrOpcode, instrOperand} == $past(uiIn);
	endproperty
	a_ir_ld: assert property (p_ir_ld) else $error("instr load");
	property p_ma_ld; s == 2'h3 && ldB |=> memAddress == $past(uiIn[3:0]); endproperty
	a_ma_ld: assert property (p_ma_ld) else $error("addr load");
	property p_md_ld; s == 2'h3 && ldA |=> memWriteData == $past(uiIn); endproperty
	a_md_ld: assert property (p_md_ld) else $error("data load");
	property p_bus_oe; wBusOe == (s == 2'h0 && ldB); endproperty
	a_bus_oe: assert property (p_bus_oe) else $error("bus enable");
	property p_bus_val; wBusOe |-> wBusOut == {instrOpcode, instrOperand}; endproperty
	a_bus_val: assert property (p_bus_val) else $error("bus value");
	c_clr_ld: cover property (!instr_clear_n && ldA && s == 2'h0);
	c_pair: cover property (s == 2'h3 && ldA && ldB);
	c_drive: cover property (wBusOe);
endmodule

// ===== tb/crs_sequencer_model.sv
// Purpose: controller driving the test pins
// Assumes: controls active low
// Notes: released bus shows inverted data
`timescale 1ns/1ps
module crs_sequencer_model (
	input wire logic clk,
	output logic [7:0] uiIn,
	output logic [7:0] uioIn,
	output logic clrN
);
	initial begin
		uiIn = 8'h00;
		uioIn = 8'h30;
		clrN = 1'b1;
	end
	task automatic put(input logic [1:0] s, input logic [7:0] d, input logic a, b, c);
		@(posedge clk);
		uiIn <= d;
		uioIn <= {s, b, a, 4'($urandom)};
		clrN <= c;
		@(posedge clk);
		uiIn <= ~d;
		uioIn <= {s, 2'h3, 4'h0};
		clrN <= 1'b1;
	endtask
endmodule

// ===== tb/test_cpu_bus_register_set.sv
// Purpose: self-checking bench for the register set
// Assumes: control override off until the final status check
// Notes: expectations queued, checked as results appear
`timescale 1ns/1ps
bind crs_register_set crs_register_set_asserts chk (.clk(clk), .sys_rst(sys_rst),
	.uiIn(uiIn), .uioIn(uioIn), .instr_clear_n(instr_clear_n), .wBusOe(wBusOe),
	.wBusOut(wBusOut),
	.instrOpcode(instrOpcode), .instrOperand(instrOperand), .displayValue(displayValue),
	.adderOperand(adderOperand), .memWriteData(memWriteData), .memAddress(memAddress));
module test_cpu_bus_register_set;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rd = 1'b0, wr = 1'b0, pk = 1'b0, clrN, wt;
	logic [7:0] uiIn, uioIn, uoOut, uioOut, uioOe;
	logic [7:0] ir = 8'h00, orr = 8'h00, br = 8'h00, md = 8'h00;
	logic [3:0] ma = 4'h0;
	logic [4:0] ad = 5'h00;
	logic [31:0] wd = 32'h0000_0000, rdd;
	logic [31:0] q[$];
	int mismatches = 0, cmp_count = 0, cyc = 0;
	always #12.5 clk = ~clk;
	crs_sequencer_model seq (.clk(clk), .uiIn(uiIn), .uioIn(uioIn), .clrN(clrN));
	crs_register_set dut (.clk(clk), .sys_rst(sys_rst), .uiIn(uiIn), .uioIn(uioIn),
		.instr_clear_n(clrN), .uoOut(uoOut), .uioOut(uioOut), .uioOe(uioOe), .wBusOut(),
		.wBusOe(), .instrOpcode(), .instrOperand(), .displayValue(), .adderOperand(),
		.memWriteData(), .memAddress(), .avsAddress(ad), .avsRead(rd), .avsWrite(wr),
		.avsWriteData(wd), .avsByteEnable(4'hF), .avsReadData(rdd), .avsWaitRequest(wt));
	task automatic chk(input logic [31:0] seen, exp, input string nm);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (pk) chk({8'h00, uioOe, uioOut, uoOut}, q.pop_front(), "pins");
		if (rd && wt === 1'b0) chk(rdd, q.pop_front(), "avs");
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			conclude();
		end
	end
	// waits on waitrequest; only the cycle ceiling ends a hang
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		ad <= a;
		wd <= d;
		do @(posedge clk); while (wt !== 1'b0);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rdx(input logic [4:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	initial begin
		logic [1:0] s;
		logic [7:0] d;
		logic a, b, c;
		void'($urandom(11));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rdx(5'h04, 32'h0000_0000);
		for (int i = 0; i < 24; i++) begin
			s = 2'(i);
			d = 8'($urandom);
			a = (i < 4 || i == 8) ? 1'b0 : 1'($urandom);
			b = 1'($urandom);
			c = (i != 8);
			seq.put(s, d, a, b, c);
			if (!c) ir = 8'h00;
			else if (s == 2'h0 && !a) ir = d;
			if (s == 2'h1 && !a) orr = d;
			if (s == 2'h2 && !a) br = d;
			if (s == 2'h3 && !a) md = d;
			if (s == 2'h3 && !b) ma = d[3:0];
			case (s)
				2'h0: q.push_back({16'h000F, 4'h0, ir[7:4], 4'h0, ir[3:0]});
				2'h1: q.push_back({24'h00_0000, orr});
				2'h2: q.push_back({24'h00_0000, br});
				default: q.push_back({16'h000F, 4'h0, ma, md});
			endcase
			pk <= 1'b1;
			@(posedge clk);
			pk <= 1'b0;
		end
		rdx(5'h04, {24'h00_0000, ir});
		rdx(5'h08, {24'h00_0000, orr});
		rdx(5'h0C, {24'h00_0000, br});
		rdx(5'h10, {24'h00_0000, md});
		rdx(5'h14, {28'h000_0000, ma});
		rdx(5'h18, 32'h0000_0003);
		rdx(5'h1C, 32'h0000_0000);
		// a write to the read-only instruction offset must leave state alone
		bus(1'b1, 5'h04, 32'hFFFF_FFFF);
		bus(1'b1, 5'h00, 32'h0000_0006);
		rdx(5'h04, {24'h00_0000, ir});
		rdx(5'h00, 32'h0000_0006);
		bus(1'b1, 5'h00, 32'h0000_0003);
		rdx(5'h18, 32'h0000_0001);
		conclude();
	end
endmodule
